// ---- hdl/etmu_consts.svh ----
`ifndef ETMU_CONSTS_SVH
`define ETMU_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ETMU_OFS_ACC16        12'h000
`define ETMU_OFS_OPERAND1     12'h004
`define ETMU_OFS_OPERAND2     12'h008
`define ETMU_OFS_STATUS       12'h00C
`define ETMU_OFS_SCAN         12'h010
`define ETMU_OFS_IRQ_STATUS   12'h014
`define ETMU_OFS_IRQ_MASK     12'h018

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ETMU_ST_FLAG_BIT      0
`define ETMU_ST_HIST_BIT      3
`define ETMU_SCAN_BIT_POS     0
`define ETMU_SCAN_OP_LSB      4
`define ETMU_SCAN_OP_MSB      5
`define ETMU_SCAN_BUSY_POS    8
`define ETMU_IRQ_DONE_BIT     0
`define ETMU_IRQ_RANGE_BIT    1
`define ETMU_IRQ_DIVZ_BIT     2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ETMU_RST_WORD         16'h0000
`define ETMU_RST_IRQ          3'h0

// ----------------------------------------------------------------
// timing counts, cycles per iterative operation
// ----------------------------------------------------------------
`define ETMU_MUL_STEPS        6'h10
`define ETMU_DIV_STEPS        6'h20

`endif

// ---- hdl/etmu_div.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "etmu_consts.svh"

module etmu_div
	import etmu_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [31:0] dividend,
	input  wire logic [15:0] divisor,
	output logic             done,
	output logic [31:0]      quotient
);

	logic [15:0] dsor;
	logic [15:0] next_dsor;
	logic [15:0] rem;
	logic [15:0] next_rem;
	logic [31:0] next_quotient;
	logic [5:0]  count;
	logic [5:0]  next_count;
	logic        next_done;
	logic [16:0] trial;
	logic [16:0] diff;

	// restoring division, one quotient bit per cycle
	always_comb
	begin
		next_dsor     = dsor;
		next_rem      = rem;
		next_quotient = quotient;
		next_count    = count;
		next_done     = 1'b0;
		trial         = {rem, quotient[31]};
		diff          = trial - {1'b0, dsor};
		if (start)
		begin
			next_dsor     = divisor;
			next_rem      = 16'h0000;
			next_quotient = dividend;
			next_count    = `ETMU_DIV_STEPS;
		end
		else if (count != 6'h00)
		begin
			if (trial >= {1'b0, dsor})
			begin
				next_rem      = diff[15:0];
				next_quotient = {quotient[30:0], 1'b1};
			end
			else
			begin
				next_rem      = trial[15:0];
				next_quotient = {quotient[30:0], 1'b0};
			end
			next_count = count - 6'h01;
			next_done  = (count == 6'h01);
		end
	end

	// state registers
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			dsor     <= 16'h0000;
			rem      <= 16'h0000;
			quotient <= 32'h00000000;
			count    <= 6'h00;
			done     <= 1'b0;
		end
		else
		begin
			dsor     <= next_dsor;
			rem      <= next_rem;
			quotient <= next_quotient;
			count    <= next_count;
			done     <= next_done;
		end
	end

endmodule : etmu_div
`default_nettype wire

// ---- hdl/etmu_mul.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "etmu_consts.svh"

module etmu_mul
	import etmu_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [15:0] multiplicand,
	input  wire logic [15:0] multiplier,
	output logic             done,
	output logic [31:0]      product
);

	logic [15:0] mcand;
	logic [15:0] next_mcand;
	logic [31:0] next_product;
	logic [5:0]  count;
	logic [5:0]  next_count;
	logic        next_done;
	logic [16:0] partial;

	// shift-add step, one multiplier bit per cycle
	always_comb
	begin
		next_mcand   = mcand;
		next_product = product;
		next_count   = count;
		next_done    = 1'b0;
		partial      = {1'b0, product[31:16]} + (product[0] ? {1'b0, mcand} : 17'h00000);
		if (start)
		begin
			next_mcand   = multiplicand;
			next_product = {16'h0000, multiplier};
			next_count   = `ETMU_MUL_STEPS;
		end
		else if (count != 6'h00)
		begin
			next_product = {partial, product[15:1]};
			next_count   = count - 6'h01;
			next_done    = (count == 6'h01);
		end
	end

	// state registers
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			mcand   <= 16'h0000;
			product <= 32'h00000000;
			count   <= 6'h00;
			done    <= 1'b0;
		end
		else
		begin
			mcand   <= next_mcand;
			product <= next_product;
			count   <= next_count;
			done    <= next_done;
		end
	end

endmodule : etmu_mul
`default_nettype wire

// ---- hdl/etmu_pkg.sv ----
`default_nettype none
// ----------------------------------------------------------------
// shared types
// ----------------------------------------------------------------
package etmu_pkg;

	typedef enum logic [1:0] {
		ETMU_OP_ADD = 2'h0,
		ETMU_OP_SUB = 2'h1,
		ETMU_OP_MUL = 2'h2,
		ETMU_OP_DIV = 2'h3
	} etmu_op_t;

	typedef enum logic [1:0] {
		ETMU_IDLE,
		ETMU_WAIT_MUL,
		ETMU_WAIT_DIV
	} etmu_state_t;

endpackage : etmu_pkg
`default_nettype wire

// ---- hdl/etmu_top.sv ----
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "etmu_consts.svh"

module etmu_top
	import etmu_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [15:0] acc16;
	logic [15:0] next_acc16;
	logic [15:0] first_operand_word;
	logic [15:0] next_first_operand_word;
	logic [15:0] second_operand_word;
	logic [15:0] next_second_operand_word;
	logic [15:0] math_status_word;
	logic [15:0] next_math_status_word;
	logic        last_bit;
	logic        next_last_bit;
	etmu_op_t    last_op;
	etmu_op_t    next_last_op;
	etmu_state_t state;
	etmu_state_t next_state;
	logic [2:0]  irq_status;
	logic [2:0]  next_irq_status;
	logic [2:0]  irq_mask;
	logic [2:0]  next_irq_mask;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic        next_irq;
	logic        busy;
	logic        access;
	logic        wr_take;
	logic        rd_take;
	logic        mapped;
	logic        mul_start;
	logic        div_start;
	logic        mul_done;
	logic        div_done;
	logic [31:0] mul_product;
	logic [31:0] div_quotient;
	logic [16:0] add_sum;
	logic [16:0] sub_diff;
	logic        scan_bit;
	etmu_op_t    scan_op;
	logic        edge_fire;
	logic [2:0]  irq_events;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------

	// engine busy while a multiply or divide iterates
	assign busy     = (state != ETMU_IDLE);
	assign access   = psel & penable;
	assign wr_take  = access & pready & pwrite & ~pslverr;
	assign rd_take  = access & pready & ~pwrite & ~pslverr;
	assign mapped   = (paddr == `ETMU_OFS_ACC16) | (paddr == `ETMU_OFS_OPERAND1) |
	                  (paddr == `ETMU_OFS_OPERAND2) | (paddr == `ETMU_OFS_STATUS) |
	                  (paddr == `ETMU_OFS_SCAN) | (paddr == `ETMU_OFS_IRQ_STATUS) |
	                  (paddr == `ETMU_OFS_IRQ_MASK);

	// scan fields and arithmetic
	assign scan_bit  = pwdata[`ETMU_SCAN_BIT_POS];
	assign scan_op   = etmu_op_t'(pwdata[`ETMU_SCAN_OP_MSB:`ETMU_SCAN_OP_LSB]);
	assign edge_fire = scan_bit & ~math_status_word[`ETMU_ST_HIST_BIT];
	assign add_sum   = {1'b0, first_operand_word} + {1'b0, acc16};
	assign sub_diff  = {1'b0, first_operand_word} - {1'b0, acc16};

	// ----------------------------------------------------------------
	// apb answer
	// ----------------------------------------------------------------

	// one wait state; writes stall while the engine is busy
	always_comb
	begin
		next_pready  = 1'b0;
		next_pslverr = 1'b0;
		next_prdata  = prdata;
		if (access & ~pready & ~(pwrite & busy))
		begin
			next_pready  = 1'b1;
			next_pslverr = ~mapped;
			next_prdata  = 32'h00000000;
			if (!pwrite)
			begin
				unique case (paddr)
					`ETMU_OFS_ACC16:      next_prdata = {16'h0000, acc16};
					`ETMU_OFS_OPERAND1:   next_prdata = {16'h0000, first_operand_word};
					`ETMU_OFS_OPERAND2:   next_prdata = {16'h0000, second_operand_word};
					`ETMU_OFS_STATUS:     next_prdata = {16'h0000, math_status_word};
					`ETMU_OFS_SCAN:       next_prdata = {23'h000000, busy, 2'h0, last_op, 3'h0, last_bit};
					`ETMU_OFS_IRQ_STATUS: next_prdata = {29'h00000000, irq_status};
					`ETMU_OFS_IRQ_MASK:   next_prdata = {29'h00000000, irq_mask};
					default:              next_prdata = 32'h00000000;
				endcase
			end
		end
	end

	// bus output registers
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else
		begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// ----------------------------------------------------------------
	// math engine
	// ----------------------------------------------------------------

	// register writes, scan evaluation and result write-back
	always_comb
	begin
		next_acc16               = acc16;
		next_first_operand_word  = first_operand_word;
		next_second_operand_word = second_operand_word;
		next_math_status_word    = math_status_word;
		next_last_bit            = last_bit;
		next_last_op             = last_op;
		next_state               = state;
		next_irq_mask            = irq_mask;
		mul_start                = 1'b0;
		div_start                = 1'b0;
		irq_events               = 3'h0;
		if (wr_take)
		begin
			unique case (paddr)
				`ETMU_OFS_ACC16:    next_acc16 = pwdata[15:0];
				`ETMU_OFS_OPERAND1: next_first_operand_word = pwdata[15:0];
				`ETMU_OFS_OPERAND2: next_second_operand_word = pwdata[15:0];
				`ETMU_OFS_STATUS:   next_math_status_word = pwdata[15:0];
				`ETMU_OFS_IRQ_MASK: next_irq_mask = pwdata[2:0];
				`ETMU_OFS_SCAN:
				begin
					next_last_bit = scan_bit;
					next_last_op  = scan_op;
					// history follows every scan
					next_math_status_word[`ETMU_ST_HIST_BIT] = scan_bit;
					if (edge_fire)
					begin
						unique case (scan_op)
							ETMU_OP_ADD:
							begin
								next_first_operand_word = add_sum[15:0];
								next_math_status_word[`ETMU_ST_FLAG_BIT] = add_sum[16];
								irq_events[`ETMU_IRQ_DONE_BIT]  = 1'b1;
								irq_events[`ETMU_IRQ_RANGE_BIT] = add_sum[16];
							end
							ETMU_OP_SUB:
							begin
								next_first_operand_word = sub_diff[15:0];
								next_math_status_word[`ETMU_ST_FLAG_BIT] = sub_diff[16];
								irq_events[`ETMU_IRQ_DONE_BIT]  = 1'b1;
								irq_events[`ETMU_IRQ_RANGE_BIT] = sub_diff[16];
							end
							ETMU_OP_MUL:
							begin
								next_math_status_word[`ETMU_ST_FLAG_BIT] = 1'b0;
								mul_start  = 1'b1;
								next_state = ETMU_WAIT_MUL;
							end
							ETMU_OP_DIV:
							begin
								if (acc16 == 16'h0000)
								begin
									// operands left untouched
									next_math_status_word[`ETMU_ST_FLAG_BIT] = 1'b1;
									irq_events[`ETMU_IRQ_DONE_BIT] = 1'b1;
									irq_events[`ETMU_IRQ_DIVZ_BIT] = 1'b1;
								end
								else
								begin
									next_math_status_word[`ETMU_ST_FLAG_BIT] = 1'b0;
									div_start  = 1'b1;
									next_state = ETMU_WAIT_DIV;
								end
							end
						endcase
					end
				end
				default:
				begin
				end
			endcase
		end
		// iterative results come back while bus writes are stalled
		unique case (state)
			ETMU_IDLE:
			begin
			end
			ETMU_WAIT_MUL:
			begin
				if (mul_done)
				begin
					next_first_operand_word  = mul_product[31:16];
					next_second_operand_word = mul_product[15:0];
					irq_events[`ETMU_IRQ_DONE_BIT] = 1'b1;
					next_state = ETMU_IDLE;
				end
			end
			ETMU_WAIT_DIV:
			begin
				if (div_done)
				begin
					next_first_operand_word  = div_quotient[31:16];
					next_second_operand_word = div_quotient[15:0];
					irq_events[`ETMU_IRQ_DONE_BIT] = 1'b1;
					next_state = ETMU_IDLE;
				end
			end
		endcase
	end

	// engine registers
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			acc16               <= `ETMU_RST_WORD;
			first_operand_word  <= `ETMU_RST_WORD;
			second_operand_word <= `ETMU_RST_WORD;
			math_status_word    <= `ETMU_RST_WORD;
			last_bit            <= 1'b0;
			last_op             <= ETMU_OP_ADD;
			state               <= ETMU_IDLE;
			irq_mask            <= `ETMU_RST_IRQ;
		end
		else
		begin
			acc16               <= next_acc16;
			first_operand_word  <= next_first_operand_word;
			second_operand_word <= next_second_operand_word;
			math_status_word    <= next_math_status_word;
			last_bit            <= next_last_bit;
			last_op             <= next_last_op;
			state               <= next_state;
			irq_mask            <= next_irq_mask;
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------

	// sticky events, read clears, a new event wins over the clear
	always_comb
	begin
		next_irq_status = irq_status;
		if (rd_take && (paddr == `ETMU_OFS_IRQ_STATUS))
		begin
			next_irq_status = 3'h0;
		end
		next_irq_status = next_irq_status | irq_events;
		next_irq        = |(next_irq_status & next_irq_mask);
	end

	// interrupt registers
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			irq_status <= `ETMU_RST_IRQ;
			irq        <= 1'b0;
		end
		else
		begin
			irq_status <= next_irq_status;
			irq        <= next_irq;
		end
	end

	// ----------------------------------------------------------------
	// iterative units
	// ----------------------------------------------------------------
	etmu_mul u_mul (
		.clock        (clock),
		.rst          (rst),
		.start        (mul_start),
		.multiplicand (acc16),
		.multiplier   (second_operand_word),
		.done         (mul_done),
		.product      (mul_product)
	);

	etmu_div u_div (
		.clock    (clock),
		.rst      (rst),
		.start    (div_start),
		.dividend ({first_operand_word, second_operand_word}),
		.divisor  (acc16),
		.done     (div_done),
		.quotient (div_quotient)
	);

endmodule : etmu_top
`default_nettype wire

// ---- tb/etmu_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "etmu_consts.svh"

module etmu_monitor
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic        irq
);
	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	logic mapped;
	logic take_rd;
	logic take_wr;

	// address map check and taken transfers
	assign mapped  = (paddr <= `ETMU_OFS_IRQ_MASK) && (paddr[1:0] == 2'h0);
	assign take_rd = psel && penable && pready && !pwrite;
	assign take_wr = psel && penable && pready && pwrite;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// ----------------------------------------------------------------
	// bus and datapath checks
	// ----------------------------------------------------------------
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	read_wait_a: assert property (psel && !penable && !pwrite |=> !pready ##1 pready)
		else $error("read not answered after one wait state");
	err_unmapped_a: assert property (pready && !mapped |-> pslverr)
		else $error("unmapped address answered without pslverr");
	err_mapped_a: assert property (pready && mapped |-> !pslverr)
		else $error("mapped address answered with pslverr");
	err_zero_a: assert property (take_rd && pslverr |-> prdata == 32'h0000_0000)
		else $error("refused read returned nonzero data");
	rdata_hold_a: assert property (!pready |-> $stable(prdata))
		else $error("prdata changed without an answer");
	status_bits_a: assert property (take_rd && paddr == `ETMU_OFS_STATUS |-> (prdata & 32'hFFFF_FFF6) == 32'h0)
		else $error("status word shows bits beyond flag and history");
	word_width_a: assert property (take_rd && paddr < `ETMU_OFS_SCAN |-> prdata[31:16] == 16'h0000)
		else $error("operand word wider than 16 bits");
	mask_off_a: assert property (take_wr && paddr == `ETMU_OFS_IRQ_MASK && pwdata[2:0] == 3'h0 |=> !irq)
		else $error("irq stays high with all sources masked");
endmodule : etmu_monitor
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "etmu_consts.svh"

module tb
	import etmu_pkg::*;
;
	localparam logic [11:0] A_ACC  = `ETMU_OFS_ACC16;
	localparam logic [11:0] A_OP1  = `ETMU_OFS_OPERAND1;
	localparam logic [11:0] A_OP2  = `ETMU_OFS_OPERAND2;
	localparam logic [11:0] A_ST   = `ETMU_OFS_STATUS;
	localparam logic [11:0] A_SCAN = `ETMU_OFS_SCAN;
	localparam logic [11:0] A_IRQ  = `ETMU_OFS_IRQ_STATUS;
	localparam logic [11:0] A_MASK = `ETMU_OFS_IRQ_MASK;

	logic        clock;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [31:0] rdata;
	logic        rerr;
	int          n_errors;
	int          comparisons;

	etmu_top dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

	// clock generation
	always #25 clock = ~clock;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task print_verdict;
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", name, exp, got);
			n_errors++;
		end
	endtask : check

	task apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
		int i;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= data;
		@(posedge clock);
		penable <= 1'b1;
		// request stands until pready is seen high at a rising edge
		for (i = 0; i < 100; i++)
		begin
			@(posedge clock);
			if (pready === 1'b1)
				break;
		end
		if (i == 100)
		begin
			n_errors++;
			print_verdict();
		end
		// answer taken at that same edge, then the request is released
		rdata = prdata;
		rerr  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd(input logic [11:0] addr, input logic [31:0] exp, input string name);
		apb(1'b0, addr, 32'h0);
		check(name, exp, rdata);
	endtask : rd

	task scan(input etmu_op_t op, input logic b);
		apb(1'b1, A_SCAN, {26'h0, op, 3'h0, b});
	endtask : scan

	task wait_idle;
		for (int i = 0; i < 20; i++)
		begin
			apb(1'b0, A_SCAN, 32'h0);
			if (rdata[`ETMU_SCAN_BUSY_POS] === 1'b0)
				return;
		end
		n_errors++;
		print_verdict();
	endtask : wait_idle

	// clear the history, then give the rising scan
	task fire(input etmu_op_t op);
		scan(op, 1'b0);
		scan(op, 1'b1);
		wait_idle();
	endtask : fire

	task chk_irq(input logic exp);
		@(negedge clock);
		check("irq", {31'h0, exp}, {31'h0, irq});
	endtask : chk_irq

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task s_reset;
		for (int i = 0; i < 7; i++)
			rd(12'(4 * i), 32'h0, "reset value");
	endtask : s_reset

	task s_add;
		apb(1'b1, A_ACC, 32'h5);
		apb(1'b1, A_OP1, 32'hFFFE);
		fire(ETMU_OP_ADD);
		rd(A_OP1, 32'h3, "add wrap");
		rd(A_ST, 32'h9, "add overflow status");
		scan(ETMU_OP_ADD, 1'b1);
		rd(A_OP1, 32'h3, "add without edge");
		scan(ETMU_OP_ADD, 1'b0);
		rd(A_ST, 32'h1, "history after low scan");
		scan(ETMU_OP_ADD, 1'b1);
		rd(A_OP1, 32'h8, "add sum");
		rd(A_ST, 32'h8, "add flag cleared");
	endtask : s_add

	task s_sub;
		apb(1'b1, A_OP1, 32'h3);
		fire(ETMU_OP_SUB);
		rd(A_OP1, 32'hFFFE, "sub wrap");
		rd(A_ST, 32'h9, "sub underflow status");
		fire(ETMU_OP_SUB);
		rd(A_OP1, 32'hFFF9, "sub difference");
		rd(A_ST, 32'h8, "sub flag cleared");
	endtask : s_sub

	task s_mul;
		apb(1'b1, A_OP1, 32'h1234);
		apb(1'b1, A_OP2, 32'hFFFF);
		apb(1'b1, A_ACC, 32'hFFFF);
		apb(1'b1, A_ST, 32'h1);
		fire(ETMU_OP_MUL);
		rd(A_OP1, 32'hFFFE, "mul high word");
		rd(A_OP2, 32'h1, "mul low word");
		rd(A_ST, 32'h8, "mul status");
	endtask : s_mul

	task s_div;
		apb(1'b1, A_OP1, 32'h2);
		apb(1'b1, A_OP2, 32'h1);
		apb(1'b1, A_ACC, 32'h2);
		fire(ETMU_OP_DIV);
		rd(A_OP1, 32'h1, "div high word");
		rd(A_OP2, 32'h0, "div low word");
		apb(1'b1, A_ACC, 32'h0);
		apb(1'b1, A_OP1, 32'h1234);
		apb(1'b1, A_OP2, 32'h5678);
		fire(ETMU_OP_DIV);
		rd(A_ST, 32'h9, "div by zero status");
		rd(A_OP1, 32'h1234, "div zero keeps high");
		rd(A_OP2, 32'h5678, "div zero keeps low");
	endtask : s_div

	task s_irq;
		rd(A_IRQ, 32'h7, "sticky events");
		rd(A_IRQ, 32'h0, "events cleared by read");
		apb(1'b1, A_MASK, 32'h7);
		apb(1'b1, A_ACC, 32'h5);
		apb(1'b1, A_OP1, 32'hFFFF);
		fire(ETMU_OP_ADD);
		chk_irq(1'b1);
		rd(A_IRQ, 32'h3, "overflow events");
		rd(A_MASK, 32'h7, "mask readback");
		chk_irq(1'b0);
		apb(1'b1, A_ACC, 32'h0);
		fire(ETMU_OP_DIV);
		apb(1'b1, A_MASK, 32'h0);
		rd(A_MASK, 32'h0, "mask cleared");
		chk_irq(1'b0);
		rd(A_IRQ, 32'h5, "divide by zero events");
		apb(1'b0, 12'h01C, 32'h0);
		check("unmapped error", 32'h1, {31'h0, rerr});
		check("unmapped data", 32'h0, rdata);
	endtask : s_irq

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		clock       = 1'b0;
		rst         = 1'b1;
		psel        = 1'b0;
		penable     = 1'b0;
		pwrite      = 1'b0;
		paddr       = 12'h000;
		pwdata      = 32'h0;
		n_errors    = 0;
		comparisons = 0;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		s_reset();
		s_add();
		s_sub();
		s_mul();
		s_div();
		s_irq();
		print_verdict();
	end
endmodule : tb

bind etmu_top etmu_monitor mon_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire
